/* File: design/rxid_pkg.sv */
// Package: register map, field layout, reset codes and drive scaling for the
// receiver output control and identification page.
// Assumes an Avalon-MM slave with byte addresses on a 32-bit data bus.
package rxid_pkg;
  localparam int          RXID_LANES         = 12;
  localparam int          RXID_PAIRS         = 6;
  localparam int          RXID_AW            = 10;
  // Byte offsets of the page; each byte sits alone in one aligned word
  localparam logic [7:0]  RXID_IDX_TYPE      = 8'h80;
  localparam logic [7:0]  RXID_IDX_PWR       = 8'h81;
  localparam logic [7:0]  RXID_IDX_SUPPLY    = 8'h82;
  localparam logic [7:0]  RXID_IDX_TCASE     = 8'h83;
  localparam logic [7:0]  RXID_IDX_RATE_MIN  = 8'h84;
  localparam logic [7:0]  RXID_IDX_RATE_MAX  = 8'h85;
  localparam logic [7:0]  RXID_IDX_WL_HI     = 8'h86;
  localparam logic [7:0]  RXID_IDX_WL_LO     = 8'h87;
  localparam logic [7:0]  RXID_IDX_TOL_HI    = 8'h88;
  localparam logic [7:0]  RXID_IDX_TOL_LO    = 8'h89;
  localparam logic [7:0]  RXID_IDX_FLAGS     = 8'h8A;
  localparam logic [7:0]  RXID_IDX_SWING0    = 8'hE4;
  localparam logic [7:0]  RXID_IDX_SWING5    = 8'hE9;
  localparam logic [7:0]  RXID_IDX_DEEMPH0   = 8'hEA;
  localparam logic [7:0]  RXID_IDX_DEEMPH5   = 8'hEF;
  // Reset codes of the lane controls
  localparam logic [3:0]  RXID_SWING_RST     = 4'h5;
  localparam logic [3:0]  RXID_DEEMPH_RST    = 4'h4;
  localparam logic [3:0]  RXID_CODE_MAX      = 4'h7;
  // Swing in mVpp: base plus step times code
  localparam int          RXID_SWING_MIN_MV  = 220;
  localparam int          RXID_SWING_STEP_MV = 90;
  // De-emphasis full scale in tenths of dB, spread over seven steps
  localparam int          RXID_DEEMPH_FS_CDB = 60;
  // Reserved-bit masks of the ID bytes
  localparam logic [7:0]  RXID_PWR_MASK      = 8'hFE;
  localparam logic [7:0]  RXID_SUPPLY_MASK   = 8'hF8;
  localparam logic [7:0]  RXID_FLAGS_MASK    = 8'hFC;
  localparam logic [31:0] RXID_RDATA_NONE    = 32'h0000_0000;
  localparam logic [1:0]  RXID_RESP_OK       = 2'h0;
  localparam logic [1:0]  RXID_RESP_DECERR   = 2'h3;
  typedef enum logic [1:0] {RXID_IDLE, RXID_ACK} rxid_bus_t;
endpackage

/* File: design/rxid_lane_drive.sv */
// Lane drive decoder: turns one lane's swing and de-emphasis codes into
// analog trim levels. Assumes codes come from the register bank flops.
`timescale 1ns/1ns
module rxid_lane_drive
  import rxid_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  swing_code,
  input  wire logic [3:0]  deemph_code,
  output logic      [9:0]  swing_mv,
  output logic      [5:0]  deemph_cdb
);
  logic [9:0] nxt_swing_mv;
  logic [5:0] nxt_deemph_cdb;
  logic [3:0] sw_eff;
  logic [3:0] de_eff;

  // Reserved codes clamp to full scale instead of an undefined level
  assign sw_eff = swing_code[3] ? RXID_CODE_MAX : swing_code;
  assign de_eff = deemph_code[3] ? RXID_CODE_MAX : deemph_code;
  assign nxt_swing_mv = 10'(RXID_SWING_MIN_MV + RXID_SWING_STEP_MV * int'(sw_eff));
  assign nxt_deemph_cdb = 6'((RXID_DEEMPH_FS_CDB * int'(de_eff)) / 7);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      swing_mv   <= 10'h000;
      deemph_cdb <= 6'h00;
    end else begin
      swing_mv   <= nxt_swing_mv;
      deemph_cdb <= nxt_deemph_cdb;
    end
  end
endmodule

/* File: design/rxid_regbank.sv */
// Register bank: per-lane receiver swing/de-emphasis codes and the
// read-only identification bytes, as an Avalon-MM slave.
// Assumes a single mclk domain and a master that holds requests.
`timescale 1ns/1ns
// Functional notes
// - Each lane has a 4-bit swing nibble
// - Swing is 220 mVpp plus 90 per code
// - Each lane has a 4-bit de-emphasis nibble
// - De-emphasis 0 to 6 dB, codes 0-7
// - Byte 0x80 reports module type code
// - Byte 0x81 bits 7-6 give power class
// - Byte 0x81 bits 5-1 give capabilities
// - Byte 0x82 flags required supplies
// - Byte 0x83 holds max case temperature
// - Bytes 0x84/0x85 hold lane rate limits
// - Bytes 0x86-0x87 hold wavelength times 20
// - Bytes 0x88-0x89 hold tolerance times 200
// - Byte 0x8A flags supported lane events
// - Flags bit 2 says warnings also provided
// - Swing codes reset to 5
// - De-emphasis codes reset to 4
module rxid_regbank
  import rxid_pkg::*;
#(
  // Arbitrary neutral identification contents
  parameter logic [7:0]  TYPE_ID    = 8'h00,
  parameter logic [1:0]  PWR_CLASS  = 2'h0,
  parameter logic [4:0]  CAPS       = 5'h00,
  parameter logic [4:0]  SUPPLIES   = 5'h00,
  parameter logic [7:0]  TCASE_MAX  = 8'h00,
  parameter logic [7:0]  RATE_MIN   = 8'h00,
  parameter logic [7:0]  RATE_MAX   = 8'h00,
  parameter logic [15:0] WAVELENGTH = 16'h0000,
  parameter logic [15:0] WL_TOL     = 16'h0000,
  parameter logic [4:0]  FLAGS_SUP  = 5'h00,
  parameter logic        ALARM_WARN = 1'b0
)
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [RXID_AW-1:0] avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  output logic      [1:0]         avs_response,
  output logic      [47:0]        rx_swing_code,
  output logic      [47:0]        rx_deemph_code,
  output logic      [119:0]       rx_swing_mv,
  output logic      [71:0]        rx_deemph_cdb
);
  rxid_bus_t   state_ff;
  logic [3:0]  swing_ff  [RXID_LANES];
  logic [3:0]  deemph_ff [RXID_LANES];
  logic [31:0] rdata_ff;
  logic [1:0]  resp_ff;
  logic [7:0]  byte_idx;
  logic        word_ok;
  logic        req;
  logic        wr_hit;
  logic [31:0] nxt_rdata;
  logic        nxt_mapped;

  // Lane served by the high nibble of a control byte; low nibble is lane-1
  function automatic int hi_lane(input logic [7:0] idx, input logic [7:0] base);
    hi_lane = RXID_LANES - 1 - 2 * int'(idx - base);
  endfunction

  function automatic logic in_range(input logic [7:0] idx, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (idx >= lo) && (idx <= hi);
  endfunction

  assign byte_idx = avs_address[9:2];
  assign word_ok  = (avs_address[1:0] == 2'h0);
  assign req      = (avs_read || avs_write) && (state_ff == RXID_IDLE);
  // Write lands at the accepting edge, when waitrequest is sampled low
  assign wr_hit   = avs_write && (state_ff == RXID_ACK) && word_ok && avs_byteenable[0];

  // One wait cycle: answer on the edge after the request is seen
  assign avs_waitrequest = (avs_read || avs_write) && (state_ff != RXID_ACK);
  assign avs_readdata    = rdata_ff;
  assign avs_response    = resp_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RXID_IDLE;
    end else begin
      case (state_ff)
        RXID_IDLE: state_ff <= req ? RXID_ACK : RXID_IDLE;
        RXID_ACK:  state_ff <= RXID_IDLE;
        default:   state_ff <= RXID_IDLE;
      endcase
    end
  end

  // Lane control nibbles; ID bytes have no storage so writes fall away
  genvar g;
  generate
    for (g = 0; g < RXID_PAIRS; g++) begin : g_pair
      localparam int HI = RXID_LANES - 1 - 2 * g;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          swing_ff[HI]    <= RXID_SWING_RST;
          swing_ff[HI-1]  <= RXID_SWING_RST;
          deemph_ff[HI]   <= RXID_DEEMPH_RST;
          deemph_ff[HI-1] <= RXID_DEEMPH_RST;
        end else if (wr_hit) begin
          // Reserved codes are stored as written; host must not send them
          if (byte_idx == RXID_IDX_SWING0 + 8'(g)) begin
            swing_ff[HI]   <= avs_writedata[7:4];
            swing_ff[HI-1] <= avs_writedata[3:0];
          end
          if (byte_idx == RXID_IDX_DEEMPH0 + 8'(g)) begin
            deemph_ff[HI]   <= avs_writedata[7:4];
            deemph_ff[HI-1] <= avs_writedata[3:0];
          end
        end
      end
    end
    for (g = 0; g < RXID_LANES; g++) begin : g_lane
      assign rx_swing_code[4*g +: 4]  = swing_ff[g];
      assign rx_deemph_code[4*g +: 4] = deemph_ff[g];
      rxid_lane_drive u_drive (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .swing_code  (swing_ff[g]),
        .deemph_code (deemph_ff[g]),
        .swing_mv    (rx_swing_mv[10*g +: 10]),
        .deemph_cdb  (rx_deemph_cdb[6*g +: 6])
      );
    end
  endgenerate

  // Read decode
  always_comb begin
    nxt_rdata  = RXID_RDATA_NONE;
    nxt_mapped = 1'b1;
    case (byte_idx)
      RXID_IDX_TYPE:     nxt_rdata[7:0] = TYPE_ID;
      RXID_IDX_PWR:      nxt_rdata[7:0] = {PWR_CLASS, CAPS, 1'b0} & RXID_PWR_MASK;
      RXID_IDX_SUPPLY:   nxt_rdata[7:0] = {SUPPLIES, 3'h0} & RXID_SUPPLY_MASK;
      RXID_IDX_TCASE:    nxt_rdata[7:0] = TCASE_MAX;
      RXID_IDX_RATE_MIN: nxt_rdata[7:0] = RATE_MIN;
      RXID_IDX_RATE_MAX: nxt_rdata[7:0] = RATE_MAX;
      RXID_IDX_WL_HI:    nxt_rdata[7:0] = WAVELENGTH[15:8];
      RXID_IDX_WL_LO:    nxt_rdata[7:0] = WAVELENGTH[7:0];
      RXID_IDX_TOL_HI:   nxt_rdata[7:0] = WL_TOL[15:8];
      RXID_IDX_TOL_LO:   nxt_rdata[7:0] = WL_TOL[7:0];
      RXID_IDX_FLAGS:    nxt_rdata[7:0] = {FLAGS_SUP, ALARM_WARN, 2'h0} & RXID_FLAGS_MASK;
      default: begin
        if (in_range(byte_idx, RXID_IDX_SWING0, RXID_IDX_SWING5)) begin
          nxt_rdata[7:4] = swing_ff[hi_lane(byte_idx, RXID_IDX_SWING0)];
          nxt_rdata[3:0] = swing_ff[hi_lane(byte_idx, RXID_IDX_SWING0) - 1];
        end else if (in_range(byte_idx, RXID_IDX_DEEMPH0, RXID_IDX_DEEMPH5)) begin
          nxt_rdata[7:4] = deemph_ff[hi_lane(byte_idx, RXID_IDX_DEEMPH0)];
          nxt_rdata[3:0] = deemph_ff[hi_lane(byte_idx, RXID_IDX_DEEMPH0) - 1];
        end else begin
          nxt_mapped = 1'b0;
        end
      end
    endcase
    if (!word_ok) begin
      nxt_mapped = 1'b0;
      nxt_rdata  = RXID_RDATA_NONE;
    end
  end

  // Registered answer; loaded on the request and held through ACK so it stands at the accepting edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= RXID_RDATA_NONE;
      resp_ff  <= RXID_RESP_OK;
    end else if (req) begin
      rdata_ff <= avs_read ? nxt_rdata : RXID_RDATA_NONE;
      resp_ff  <= nxt_mapped ? RXID_RESP_OK : RXID_RESP_DECERR;
    end
  end
endmodule

/* File: tb/rxid_regbank_properties.sv */
// Checker: lane-code and readback properties of the register bank.
// Assumes a bind to rxid_regbank in one mclk domain.
`timescale 1ns/1ns
module rxid_chk
  import rxid_pkg::*;
(
  input wire logic [RXID_AW-1:0] avs_address,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic [47:0]        rx_swing_code,
  input wire logic [47:0]        rx_deemph_code,
  input wire logic [119:0]       rx_swing_mv,
  input wire logic [71:0]        rx_deemph_cdb,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic               mclk,
  input wire logic               rst_n
);
  logic [7:0] ofs;
  logic [3:0] cs;
  logic [3:0] cd;
  assign ofs = avs_address[9:2];
  // Reserved codes drive as full scale
  assign cs = rx_swing_code[3] ? RXID_CODE_MAX : rx_swing_code[3:0];
  assign cd = rx_deemph_code[3] ? RXID_CODE_MAX : rx_deemph_code[3:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(lo, hi);
    avs_write && !avs_waitrequest && avs_byteenable[0] && !avs_address[1:0] && ofs >= lo && ofs <= hi;
  endsequence
  AST_SWING_RST: assert property ($rose(rst_n) |-> rx_swing_code == {12{RXID_SWING_RST}})
    else $error("swing code reset");
  AST_DEEMPH_RST: assert property ($rose(rst_n) |-> rx_deemph_code == {12{RXID_DEEMPH_RST}})
    else $error("deemph code reset");
  AST_SWING_MV: assert property ($past(rst_n) |-> rx_swing_mv[9:0] == 10'(220 + 90 * $past(cs)))
    else $error("swing level");
  AST_DEEMPH_CDB: assert property ($past(rst_n) |-> rx_deemph_cdb[5:0] == 6'(60 * $past(cd) / 7))
    else $error("deemph level");
  AST_SWING_WR: assert property (s_wr(8'hE4, 8'hE9) |=>
    rx_swing_code[8*(8'hE9-$past(ofs)) +: 8] == $past(avs_writedata[7:0])) else $error("swing write");
  AST_DEEMPH_WR: assert property (s_wr(8'hEA, 8'hEF) |=>
    rx_deemph_code[8*(8'hEF-$past(ofs)) +: 8] == $past(avs_writedata[7:0])) else $error("deemph write");
  AST_ID_RO: assert property (s_wr(8'h80, 8'h8A) |=> $stable(rx_swing_code) ##0 $stable(rx_deemph_code))
    else $error("id write changed codes");
  AST_CAPS_RESV: assert property (avs_read && avs_waitrequest && avs_address == 10'h204 |=>
    avs_readdata[0] == 1'b0) else $error("caps reserved bit");
endmodule
bind rxid_regbank rxid_chk u_chk (.*);

/* File: tb/rxid_host_model.sv */
// Host model: Avalon-MM master, one transfer at a time.
// Assumes each call starts just after a rising mclk edge.
`timescale 1ns/1ns
module rxid_host_model
  import rxid_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic [31:0]        avs_readdata,
  input  wire logic               avs_waitrequest,
  input  wire logic [1:0]         avs_response,
  output logic      [RXID_AW-1:0] avs_address    = '0,
  output logic                    avs_read       = 1'b0,
  output logic                    avs_write      = 1'b0,
  output logic      [31:0]        avs_writedata  = '0,
  output logic      [3:0]         avs_byteenable = 4'h0
);
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] v,
                      input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, v & 8'h77}; // Never a reserved code
    avs_byteenable <= be;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines show the inverse, not a stale copy
    avs_address <= ~a;
    avs_writedata <= ~avs_writedata;
    @(posedge mclk);
  endtask
endmodule

/* File: tb/rx_output_ctrl_and_id_page_tb_top.sv */
// Testbench: register bank against a lane-code model in an int array.
// Assumes the host model carries all bus traffic.
`timescale 1ns/1ns
module rx_output_ctrl_and_id_page_tb_top import rxid_pkg::*;;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [RXID_AW-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, r;
  logic [47:0] rx_swing_code, rx_deemph_code;
  logic [119:0] rx_swing_mv;
  logic [71:0] rx_deemph_cdb;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;
  int lc [24];
  // Arbitrary identity contents
  // Bytes left at their zero defaults read as unspecified
  localparam logic [7:0] ID [11] = '{8'h00, 8'hAA, 8'hC8, 8'h00, 8'h00, 8'h00,
                                    8'h00, 8'h00, 8'h00, 8'h00, 8'hDC};
  always #50 mclk = ~mclk;
  rxid_host_model u_rxid_host_model (.*);
  rxid_regbank #(.PWR_CLASS(2'h2), .CAPS(5'h15), .SUPPLIES(5'h19),
    .FLAGS_SUP(5'h1B), .ALARM_WARN(1'b1)) u_rxid_regbank (.*);
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  // High lane of byte k; swing lanes 0..11, de-emphasis 12..23
  function automatic int hi(input int k);
    return k / 6 * 12 + 11 - 2 * (k % 6);
  endfunction
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    u_rxid_host_model.xfer(1'b0, a, 8'h00, 4'h1, d, r);
    cmp("readdata", {24'h0, e}, d);
    cmp("response", {30'h0, er}, r);
  endtask
  task automatic wr(input int k, input logic [7:0] v, input logic [3:0] e);
    u_rxid_host_model.xfer(1'b1, 10'(('hE4 + k) * 4), v, e, d, r);
    if (e[0] && k >= 0 && k < 12) begin
      lc[hi(k)] = v[6:4];
      lc[hi(k) - 1] = v[2:0];
    end
  endtask
  task automatic lanes();
    for (int g = 0; g < 12; g++) begin
      cmp("swing code", 32'(lc[g]), 32'(rx_swing_code[4*g +: 4]));
      cmp("deemph code", 32'(lc[12+g]), 32'(rx_deemph_code[4*g +: 4]));
      cmp("swing mv", 32'(220 + 90 * lc[g]), 32'(rx_swing_mv[10*g +: 10]));
      cmp("deemph cdb", 32'(60 * lc[12+g] / 7), 32'(rx_deemph_cdb[6*g +: 6]));
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(91));
    foreach (lc[i]) lc[i] = i < 12 ? 5 : 4;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    lanes();
    for (int o = 0; o < 11; o++) begin
      wr(o - 'h64, ~ID[o], 4'h1);
      rd(10'((o + 'h80) * 4), ID[o], RXID_RESP_OK);
    end
    for (int i = 0; i < 40; i++) begin
      k = $urandom_range(11);
      wr(k, i < 2 ? 8'h70 >> (4 * i) : 8'($urandom), i < 2 ? 4'h1 : 4'($urandom));
      rd(10'(('hE4 + k) * 4), {1'b0, 3'(lc[hi(k)]), 1'b0, 3'(lc[hi(k) - 1])}, RXID_RESP_OK);
      lanes();
    end
    // Mid-run reset must bring every lane back to its default
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (lc[i]) lc[i] = i < 12 ? 5 : 4;
    repeat (2) @(posedge mclk);
    lanes();
    wr(20, 8'h11, 4'h1);
    rd(10'h3F0, 8'h00, RXID_RESP_DECERR);
    rd(10'h391, 8'h00, RXID_RESP_DECERR);
    lanes();
    close_out();
  end
endmodule
